// ==== dvp_vector_unit.sv ====
/*
  Vector command sequencer and datapath: polynomial, QAM decision, distance, FFT pass, IIR.
  Assumes a synchronous word memory returning read data the cycle after mem_rd_out is high,
  and taking a write in the cycle mem_wr_out is high.
*/
`timescale 1ns/1ps
module dvp_vector_unit (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  input wire logic [15:0] element_count_in,
  input wire logic [15:0] x_base_in,
  input wire logic [15:0] y_base_in,
  input wire logic [15:0] z_base_in,
  input wire logic round_select_bit_in,
  input wire logic [15:0] mem_rdata_in,
  output logic busy_out,
  output logic cmd_done_out,
  output logic cmd_reject_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic [15:0] y_addr_out
);
  dvp_pkg::dvp_state_type state_reg, state_next;
  dvp_pkg::dvp_cmd_type cmd_reg, cmd_next, dec_cmd;
  dvp_pkg::dvp_phase_type phase_reg, phase_next, adv_phase;
  dvp_pkg::dvp_state_type adv_state;
  logic [15:0] n_reg, n_next, adv_n, cnt_reg, cnt_next;
  logic [15:0] xb_reg, xb_next, yb_reg, yb_next, zb_reg, zb_next;
  logic [2:0] k_reg, k_next;
  logic signed [15:0] op_reg [0:5];
  logic signed [15:0] op_next [0:5];
  logic signed [15:0] ycon_reg [0:7];
  logic signed [15:0] ycon_next [0:7];
  logic signed [15:0] temp_reg, temp_next;
  logic [31:0] acc_reg, acc_next;
  logic rnd_reg, rnd_next;
  logic busy_next, done_next, rej_next, rd_next, wr_next;
  logic [15:0] addr_next, wdata_next, yptr_next;
  logic dec_ok, accept;
  // datapath terms
  logic [2:0] nrd, nwr;
  logic [15:0] rd_addr, wr_addr, wr_data, e, e2, kw;
  logic signed [31:0] t1, t2, ir, ii;
  logic signed [16:0] dr, di;
  logic signed [15:0] cr, ci, pre, pim;
  logic signed [47:0] prod;
  logic [47:0] conv;
  logic [31:0] ro;
  localparam logic [15:0] WORD0 = dvp_pkg::WORD_RESET;

  always_comb begin
    dec_ok = (cmd_word_in[15:11] == dvp_pkg::CMD_PREFIX);
    dec_cmd = dvp_pkg::C_POLY;
    unique case (cmd_word_in[10:0])
      dvp_pkg::CODE_POLY: dec_cmd = dvp_pkg::C_POLY;
      dvp_pkg::CODE_DECIDE: dec_cmd = dvp_pkg::C_DECIDE;
      dvp_pkg::CODE_DIST: dec_cmd = dvp_pkg::C_DIST;
      dvp_pkg::CODE_FFT: dec_cmd = dvp_pkg::C_FFT;
      dvp_pkg::CODE_IIR: dec_cmd = dvp_pkg::C_IIR;
      default: dec_ok = 1'b0;
    endcase
    accept = cmd_valid_in && (state_reg == dvp_pkg::S_IDLE) && dec_ok;
  end

  // per-command address, count and arithmetic
  always_comb begin
    e = (phase_reg == dvp_pkg::PH_POST) ? cnt_reg : n_reg;
    e2 = {e[14:0], 1'b0};
    kw = {13'h0000, k_reg};
    nrd = 3'd1;
    nwr = 3'd0;
    rd_addr = xb_reg;
    wr_addr = zb_reg;
    wr_data = WORD0;
    t1 = '0;
    t2 = '0;
    ir = '0;
    ii = '0;
    dr = '0;
    di = '0;
    cr = '0;
    ci = '0;
    pre = '0;
    pim = '0;
    prod = '0;
    conv = '0;
    ro = '0;
    unique case (cmd_reg)
      dvp_pkg::C_POLY: begin
        if (phase_reg == dvp_pkg::PH_PRE) begin
          nrd = 3'd2;
          rd_addr = (k_reg == 3'd0) ? yb_reg : xb_reg;
          t1 = ycon_reg[0] * ycon_reg[1];
        end else if (phase_reg == dvp_pkg::PH_BODY) begin
          nrd = 3'd4;
          nwr = 3'd2;
          rd_addr = (k_reg < 3'd2) ? xb_reg + e2 + 16'h0002 + kw : zb_reg + e2 + kw - 16'h0002;
          wr_addr = zb_reg + e2 + kw;
          t1 = op_reg[2] * op_reg[0] - op_reg[3] * op_reg[1];
          t2 = op_reg[2] * op_reg[1] + op_reg[3] * op_reg[0];
          wr_data = (k_reg == 3'd0) ? t1[30:15] + temp_reg : t2[30:15];
        end else begin
          nrd = 3'd2;
          nwr = 3'd1;
          rd_addr = (k_reg == 3'd0) ? zb_reg + e2 : xb_reg + e2 + 16'h0002;
          t1 = op_reg[0] * op_reg[1];
          t2 = ycon_reg[0] * temp_reg;
          wr_data = t1[30:15] + t2[30:15];
          wr_addr = zb_reg + e2;
        end
      end
      dvp_pkg::C_DECIDE: begin
        if (phase_reg == dvp_pkg::PH_PRE) begin
          nrd = 3'd0;
          rd_addr = yb_reg + kw;
        end else begin
          nrd = 3'd2;
          nwr = 3'd3;
          rd_addr = xb_reg + e2 + kw;
          cr = (op_reg[0] < ycon_reg[0]) ? op_reg[0] : ycon_reg[0];
          ci = (op_reg[1] < ycon_reg[1]) ? op_reg[1] : ycon_reg[1];
          cr = (cr > ycon_reg[2]) ? cr : ycon_reg[2];
          ci = (ci > ycon_reg[3]) ? ci : ycon_reg[3];
          ir = cr * ycon_reg[4];
          ii = ci * ycon_reg[5];
          // q15 products, like every other product of the unit
          t1 = {16'h0000, (ir[30:15] & ycon_reg[6]) | (ii[30:15] & ycon_reg[7])};
          wr_addr = (k_reg == 3'd2) ? zb_reg + e : xb_reg + e2 + kw;
          wr_data = (k_reg == 3'd0) ? cr : (k_reg == 3'd1) ? ci : t1[15:0];
        end
      end
      dvp_pkg::C_DIST: begin
        nrd = 3'd4;
        nwr = 3'd1;
        rd_addr = (k_reg < 3'd2) ? xb_reg + e2 + kw : yb_reg + e2 + kw - 16'h0002;
        dr = op_reg[0] - op_reg[2];
        di = op_reg[1] - op_reg[3];
        t1 = dr * dr + di * di;
        wr_addr = zb_reg + e;
        wr_data = t1[30:15];
      end
      dvp_pkg::C_FFT: begin
        nrd = 3'd6;
        nwr = 3'd4;
        rd_addr = (k_reg < 3'd2) ? xb_reg + e2 + kw :
                  (k_reg < 3'd4) ? yb_reg + e2 + kw - 16'h0002 : zb_reg + e2 + kw - 16'h0004;
        t1 = op_reg[0] * op_reg[2] - op_reg[1] * op_reg[3];
        t2 = op_reg[0] * op_reg[3] + op_reg[1] * op_reg[2];
        pre = t1[30:15];
        pim = t2[30:15];
        wr_addr = (k_reg < 3'd2) ? yb_reg + e2 + kw : zb_reg + e2 + kw - 16'h0002;
        unique case (k_reg)
          3'd0: wr_data = op_reg[4] - pre;
          3'd1: wr_data = op_reg[5] - pim;
          3'd2: wr_data = op_reg[4] + pre;
          default: wr_data = op_reg[5] + pim;
        endcase
      end
      dvp_pkg::C_IIR: begin
        if (phase_reg == dvp_pkg::PH_PRE) begin
          rd_addr = yb_reg;
        end else begin
          nrd = 3'd2;
          nwr = 3'd1;
          rd_addr = (k_reg == 3'd0) ? xb_reg + e : yb_reg + e + 16'h0002;
          prod = $signed(acc_reg) * op_reg[0];
          conv = (prod + (rnd_reg ? dvp_pkg::PROD_HALF : 48'h0)) >>> 15;
          ro = acc_reg + ((ycon_reg[0] == dvp_pkg::OUT_ROUND_WORD) ? dvp_pkg::OUT_HALF : 32'h0);
          wr_addr = zb_reg + e;
          wr_data = ro[31:16];
        end
      end
    endcase
    if (cmd_reg == dvp_pkg::C_DECIDE && phase_reg == dvp_pkg::PH_PRE)
      nrd = 3'd0;
  end

  // where to go once an element or phase has finished
  always_comb begin
    adv_state = dvp_pkg::S_RD;
    adv_phase = dvp_pkg::PH_BODY;
    adv_n = WORD0;
    if (phase_reg == dvp_pkg::PH_BODY) begin
      adv_n = n_reg + 16'h0001;
      if (adv_n >= cnt_reg) begin
        adv_phase = dvp_pkg::PH_POST;
        adv_state = (cmd_reg == dvp_pkg::C_POLY) ? dvp_pkg::S_RD : dvp_pkg::S_DONE;
      end
    end else if (phase_reg == dvp_pkg::PH_POST) begin
      adv_phase = dvp_pkg::PH_POST;
      adv_state = dvp_pkg::S_DONE;
    end
  end

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    phase_next = phase_reg;
    n_next = n_reg;
    k_next = k_reg;
    cnt_next = cnt_reg;
    xb_next = xb_reg;
    yb_next = yb_reg;
    zb_next = zb_reg;
    op_next = op_reg;
    ycon_next = ycon_reg;
    temp_next = temp_reg;
    acc_next = acc_reg;
    rnd_next = rnd_reg;
    busy_next = busy_out;
    done_next = 1'b0;
    rej_next = cmd_valid_in && !accept;
    rd_next = 1'b0;
    wr_next = 1'b0;
    addr_next = mem_addr_out;
    wdata_next = mem_wdata_out;
    yptr_next = y_addr_out;
    unique case (state_reg)
      dvp_pkg::S_IDLE: if (accept) begin
        busy_next = 1'b1;
        cmd_next = dec_cmd;
        cnt_next = element_count_in;
        xb_next = x_base_in;
        yb_next = y_base_in;
        zb_next = z_base_in;
        yptr_next = y_base_in;
        rnd_next = round_select_bit_in;
        n_next = WORD0;
        k_next = 3'd0;
        phase_next = (dec_cmd == dvp_pkg::C_DIST || dec_cmd == dvp_pkg::C_FFT) ? dvp_pkg::PH_BODY : dvp_pkg::PH_PRE;
        state_next = (element_count_in == WORD0) ? dvp_pkg::S_DONE : dvp_pkg::S_RD;
      end
      dvp_pkg::S_RD: begin
        rd_next = 1'b1;
        addr_next = rd_addr;
        state_next = dvp_pkg::S_WAIT;
      end
      dvp_pkg::S_WAIT: state_next = dvp_pkg::S_CAP;
      dvp_pkg::S_CAP: begin
        if (phase_reg == dvp_pkg::PH_PRE)
          ycon_next[k_reg] = mem_rdata_in;
        else
          op_next[k_reg] = mem_rdata_in;
        k_next = k_reg + 3'd1;
        if (k_next == ((cmd_reg == dvp_pkg::C_DECIDE && phase_reg == dvp_pkg::PH_PRE) ? 3'd0 : nrd))
          state_next = dvp_pkg::S_CALC;
        else
          state_next = dvp_pkg::S_RD;
      end
      dvp_pkg::S_CALC: begin
        k_next = 3'd0;
        if (cmd_reg == dvp_pkg::C_POLY && phase_reg == dvp_pkg::PH_PRE)
          temp_next = t1[30:15];
        if (cmd_reg == dvp_pkg::C_IIR && phase_reg == dvp_pkg::PH_BODY)
          acc_next = conv[31:0] + {op_reg[1], 16'h0000};
        if (nwr != 3'd0 && phase_reg != dvp_pkg::PH_PRE) begin
          state_next = dvp_pkg::S_WR;
        end else begin
          state_next = adv_state;
          phase_next = adv_phase;
          n_next = adv_n;
        end
      end
      dvp_pkg::S_WR: begin
        wr_next = 1'b1;
        addr_next = wr_addr;
        wdata_next = wr_data;
        state_next = dvp_pkg::S_WRW;
      end
      dvp_pkg::S_WRW: begin
        k_next = k_reg + 3'd1;
        if (k_next == nwr) begin
          k_next = 3'd0;
          state_next = adv_state;
          phase_next = adv_phase;
          n_next = adv_n;
        end else begin
          state_next = dvp_pkg::S_WR;
        end
      end
      dvp_pkg::S_DONE: begin
        busy_next = 1'b0;
        done_next = 1'b1;
        if (cmd_reg == dvp_pkg::C_POLY)
          yptr_next = yb_reg + dvp_pkg::Y_PTR_ADVANCE;
        state_next = dvp_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= dvp_pkg::S_IDLE;
      cmd_reg <= dvp_pkg::C_POLY;
      phase_reg <= dvp_pkg::PH_PRE;
      n_reg <= WORD0;
      k_reg <= 3'd0;
      cnt_reg <= WORD0;
      xb_reg <= WORD0;
      yb_reg <= WORD0;
      zb_reg <= WORD0;
      for (int i = 0; i < 6; i++) op_reg[i] <= WORD0;
      for (int i = 0; i < 8; i++) ycon_reg[i] <= WORD0;
      temp_reg <= WORD0;
      acc_reg <= dvp_pkg::ACC_RESET;
      rnd_reg <= 1'b0;
      busy_out <= 1'b0;
      cmd_done_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= WORD0;
      mem_wdata_out <= WORD0;
      y_addr_out <= WORD0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      phase_reg <= phase_next;
      n_reg <= n_next;
      k_reg <= k_next;
      cnt_reg <= cnt_next;
      xb_reg <= xb_next;
      yb_reg <= yb_next;
      zb_reg <= zb_next;
      op_reg <= op_next;
      ycon_reg <= ycon_next;
      temp_reg <= temp_next;
      acc_reg <= acc_next;
      rnd_reg <= rnd_next;
      busy_out <= busy_next;
      cmd_done_out <= done_next;
      cmd_reject_out <= rej_next;
      mem_rd_out <= rd_next;
      mem_wr_out <= wr_next;
      mem_addr_out <= addr_next;
      mem_wdata_out <= wdata_next;
      y_addr_out <= yptr_next;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rd_pulse;
    mem_rd_out ##1 !mem_rd_out;
  endsequence
  property p_accept_busy;
    accept && element_count_in != WORD0 |=> busy_out ##1 busy_out;
  endproperty
  a_accept_busy: assert property (p_accept_busy) else $error("busy not raised on accept");
  property p_bad_code;
    cmd_valid_in && !busy_out && !dec_ok |=> cmd_reject_out && !busy_out;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unknown command taken");
  property p_done_ends_busy;
    cmd_done_out |-> !busy_out && $past(busy_out);
  endproperty
  a_done_ends_busy: assert property (p_done_ends_busy) else $error("done without busy fall");
  property p_read_pulse;
    state_reg == dvp_pkg::S_RD |=> s_rd_pulse;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read strobe malformed");
  property p_poly_yptr;
    cmd_done_out && cmd_reg == dvp_pkg::C_POLY |-> y_addr_out == yb_reg + dvp_pkg::Y_PTR_ADVANCE;
  endproperty
  a_poly_yptr: assert property (p_poly_yptr) else $error("Y pointer not advanced");
  property p_iir_trunc;
    mem_wr_out && cmd_reg == dvp_pkg::C_IIR && ycon_reg[0] == WORD0 |-> mem_wdata_out == acc_reg[31:16];
  endproperty
  a_iir_trunc: assert property (p_iir_trunc) else $error("filter output not truncated");
  property p_iir_acc_hold;
    state_reg == dvp_pkg::S_WR && cmd_reg == dvp_pkg::C_IIR |=> $stable(acc_reg) [*2];
  endproperty
  a_iir_acc_hold: assert property (p_iir_acc_hold) else $error("accumulator moved during write");
  property p_fft_pair;
    mem_wr_out && cmd_reg == dvp_pkg::C_FFT && k_reg == 3'd2
      |-> 16'(mem_wdata_out + $past(mem_wdata_out, 4)) == 16'({op_reg[4], 1'b0});
  endproperty
  a_fft_pair: assert property (p_fft_pair) else $error("butterfly sum wrong");
  property p_decide_clamp;
    mem_wr_out && cmd_reg == dvp_pkg::C_DECIDE && k_reg == 3'd0 |-> $signed(mem_wdata_out) >= ycon_reg[2];
  endproperty
  a_decide_clamp: assert property (p_decide_clamp) else $error("decision not clamped");
endmodule

// ==== dvp_pkg.sv ====
/*
  Constants and types for the vector command datapath: command codes, fixed-point
  scaling, rounding constants and reset values. Assumes 16-bit word-addressed operand memory.
*/
package dvp_pkg;
  localparam logic [4:0] CMD_PREFIX = 5'h10;
  localparam logic [10:0] CODE_POLY = 11'h518;
  localparam logic [10:0] CODE_DECIDE = 11'h4f0;
  localparam logic [10:0] CODE_DIST = 11'h4fe;
  localparam logic [10:0] CODE_FFT = 11'h106;
  localparam logic [10:0] CODE_IIR = 11'h537;
  localparam logic [15:0] OUT_ROUND_WORD = 16'h0080;
  localparam logic [47:0] PROD_HALF = 48'h000000004000;
  localparam logic [31:0] OUT_HALF = 32'h00008000;
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] Y_PTR_ADVANCE = 16'h0001;
  typedef enum logic [2:0] {C_POLY, C_DECIDE, C_DIST, C_FFT, C_IIR} dvp_cmd_type;
  typedef enum logic [1:0] {PH_PRE, PH_BODY, PH_POST} dvp_phase_type;
  typedef enum logic [2:0] {S_IDLE, S_RD, S_WAIT, S_CAP, S_CALC, S_WR, S_WRW, S_DONE} dvp_state_type;
endpackage

// ==== dvp_mem_model.sv ====
/*
  Operand memory model standing behind the vector unit: 256 words, one-cycle read latency.
  Assumes strobes and address change just after the rising edge and hold for one cycle.
*/
`timescale 1ns/1ps
module dvp_mem_model (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:255];
  initial rdata_out = 16'h0000;
  always @(posedge clk_in) begin
    // no read: scramble so a stale word is never trusted
    rdata_out <= rd_in ? mem[addr_in[7:0]] : ~rdata_out;
    if (wr_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
  end
endmodule

// ==== testbench.sv ====
/*
  Self-checking bench for the vector unit: random operands, reference memory, reject cases.
  Assumes the unit and the memory model share one 40 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  localparam int XB = 0;
  localparam int YB = 64;
  localparam int ZB = 128;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic rnd_sel = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic busy, done, rej, rd, wr;
  logic [15:0] addr, wdata, rdata, yaddr;
  logic [15:0] exp_mem [0:255];
  logic [10:0] codes [5] = '{dvp_pkg::CODE_DIST, dvp_pkg::CODE_FFT, dvp_pkg::CODE_POLY,
                             dvp_pkg::CODE_DECIDE, dvp_pkg::CODE_IIR};
  int n_errors = 0;
  int check_count = 0;
  // filter accumulator survives between commands, as in the unit
  logic [31:0] acc_m = 32'h00000000;
  bit rnd_m = 1'b0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  dvp_vector_unit uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid),
    .cmd_word_in(cmd_word), .element_count_in(cnt), .x_base_in(16'(XB)), .y_base_in(16'(YB)),
    .z_base_in(16'(ZB)), .round_select_bit_in(rnd_sel), .mem_rdata_in(rdata), .busy_out(busy),
    .cmd_done_out(done), .cmd_reject_out(rej), .mem_rd_out(rd), .mem_wr_out(wr),
    .mem_addr_out(addr), .mem_wdata_out(wdata), .y_addr_out(yaddr));
  dvp_mem_model mem_i (.clk_in(sys_clk_in), .rd_in(rd), .wr_in(wr), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk1(string nm, logic got, logic e);
    check_count++;
    if (got !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, got);
    end
  endtask
  task automatic chk16(string nm, logic [15:0] got, logic [15:0] e);
    check_count++;
    if (got !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask
  // q15 product; operands are multiples of 256 so no fraction bits are lost
  function automatic logic [15:0] mul(logic [15:0] a, logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return p[30:15];
  endfunction
  function automatic logic [15:0] rv();
    logic [6:0] t;
    t = 7'($urandom());
    return {t[6], t, 8'h00};
  endfunction
  function automatic logic [15:0] smin(logic [15:0] a, logic [15:0] b);
    return ($signed(a) < $signed(b)) ? a : b;
  endfunction
  task automatic put(int a, logic [15:0] v);
    mem_i.mem[a] = v;
    exp_mem[a] = v;
  endtask
  task automatic model(input logic [10:0] code, input int L);
    logic [15:0] t, ar, ai, br, bi, cr, ci;
    logic signed [47:0] p;
    logic [31:0] o;
    t = mul(exp_mem[YB], exp_mem[XB]);
    for (int n = 0; n < L; n++) begin
      ar = exp_mem[XB+2*n];
      ai = exp_mem[XB+2*n+1];
      br = exp_mem[YB+2*n];
      bi = exp_mem[YB+2*n+1];
      cr = exp_mem[ZB+2*n];
      ci = exp_mem[ZB+2*n+1];
      case (code)
        dvp_pkg::CODE_DIST: exp_mem[ZB+n] = mul(ar-br, ar-br) + mul(ai-bi, ai-bi);
        dvp_pkg::CODE_FFT: begin
          exp_mem[YB+2*n] = cr - (mul(ar, br) - mul(ai, bi));
          exp_mem[YB+2*n+1] = ci - (mul(ar, bi) + mul(ai, br));
          exp_mem[ZB+2*n] = cr + mul(ar, br) - mul(ai, bi);
          exp_mem[ZB+2*n+1] = ci + mul(ar, bi) + mul(ai, br);
        end
        dvp_pkg::CODE_POLY: begin
          ar = exp_mem[XB+2*n+2];
          ai = exp_mem[XB+2*n+3];
          exp_mem[ZB+2*n] = mul(cr, ar) - mul(ci, ai) + t;
          exp_mem[ZB+2*n+1] = mul(cr, ai) + mul(ci, ar);
        end
        dvp_pkg::CODE_DECIDE: begin
          ar = ~smin(~smin(ar, exp_mem[YB]), ~exp_mem[YB+2]);
          ai = ~smin(~smin(ai, exp_mem[YB+1]), ~exp_mem[YB+3]);
          exp_mem[XB+2*n] = ar;
          exp_mem[XB+2*n+1] = ai;
          exp_mem[ZB+n] = (mul(ar, exp_mem[YB+4]) & exp_mem[YB+6]) |
                          (mul(ai, exp_mem[YB+5]) & exp_mem[YB+7]);
        end
        dvp_pkg::CODE_IIR: begin
          p = $signed(acc_m) * $signed(exp_mem[XB+n]);
          p = p + (rnd_m ? dvp_pkg::PROD_HALF : 48'h000000000000);
          acc_m = p[46:15] + {exp_mem[YB+n+2], 16'h0000};
          o = acc_m + ((exp_mem[YB] == dvp_pkg::OUT_ROUND_WORD) ? dvp_pkg::OUT_HALF : 32'h00000000);
          exp_mem[ZB+n] = o[31:16];
        end
        default: ;
      endcase
    end
    if (code == dvp_pkg::CODE_POLY) begin
      exp_mem[ZB+2*L] = mul(exp_mem[ZB+2*L], exp_mem[XB+2*L+2]) + mul(exp_mem[YB], t);
    end
  endtask
  task automatic run_cmd(input logic [15:0] w, input int L, input bit poke);
    bit seen;
    seen = 0;
    @(posedge sys_clk_in);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    cnt <= 16'(L);
    rnd_sel <= rnd_m;
    @(posedge sys_clk_in);
    cmd_valid <= 1'b0;
    #1 chk1("busy", busy, 1'b1);
    for (int i = 0; i < 5000 && !seen; i++) begin
      @(posedge sys_clk_in);
      // a second command while busy must be turned away
      if (poke && i == 2) cmd_valid <= 1'b1;
      if (poke && i == 3) cmd_valid <= 1'b0;
      #1;
      if (poke && i == 3) chk1("reject", rej, 1'b1);
      if (done === 1'b1) begin
        seen = 1;
        chk1("busy_end", busy, 1'b0);
      end
    end
    if (!seen) begin
      n_errors++;
      $display("ERROR done expected 1 seen 0");
      complete_run();
    end
  endtask
  initial begin
    logic [10:0] code;
    logic [15:0] bad [2];
    int L, s;
    s = $urandom(32'h16c4);
    bad = '{{5'h10, 11'h000}, {5'h11, dvp_pkg::CODE_DIST}};
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    #1 chk1("busy_rst", busy, 1'b0);
    chk1("wr_rst", wr, 1'b0);
    chk16("yaddr_rst", yaddr, 16'h0000);
    foreach (bad[b]) begin
      @(posedge sys_clk_in);
      cmd_valid <= 1'b1;
      cmd_word <= bad[b];
      @(posedge sys_clk_in);
      cmd_valid <= 1'b0;
      #1 chk1("bad_reject", rej, 1'b1);
      chk1("bad_busy", busy, 1'b0);
    end
    for (int k = 0; k < 10; k++) begin
      code = codes[k%5];
      L = $urandom_range(2, 6);
      rnd_m = 1'($urandom());
      for (int a = 0; a < 256; a++) put(a, rv());
      if (code == dvp_pkg::CODE_POLY) put(YB, 16'h4000);
      if (code == dvp_pkg::CODE_DECIDE) begin
        // table read linearly; step 1, wrap 8 assumed by software
        for (int j = 0; j < 2; j++) put(YB+j, {2'b00, 6'($urandom()), 8'h00});
        for (int j = 2; j < 4; j++) put(YB+j, {2'b11, 6'($urandom()), 8'h00});
        for (int j = 6; j < 8; j++) put(YB+j, 16'($urandom()));
      end
      if (code == dvp_pkg::CODE_IIR) begin
        put(YB, (k >= 5) ? 16'h0080 : 16'h0000);
        put(YB+1, 16'h7fff);
      end
      model(code, L);
      run_cmd({dvp_pkg::CMD_PREFIX, code}, L, k < 5);
      // every word, touched or not, against the reference image
      for (int a = 0; a < 256; a++) begin
        chk16("mem", mem_i.mem[a], exp_mem[a]);
      end
      chk16("yaddr", yaddr, 16'(YB + (code == dvp_pkg::CODE_POLY)));
      $display("test %0d code %h count %0d ended", k, code, L);
    end
    complete_run();
  end
endmodule
